// ---- crl_regs.svh ----
// Offsets, field positions, codes and reset values of the control bank.
// Assumes inclusion by the bank module only.
`ifndef CRL_REGS_SVH
`define CRL_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define CRL_OFF_KEY     4'h3
`define CRL_OFF_CFG_A   4'h4
`define CRL_OFF_WORD8   4'ha
`define CRL_OFF_WORD9   4'hb
`define CRL_OFF_WORD10  4'hc

// ----------------------------------------------------------------------
// Fields and codes
// ----------------------------------------------------------------------
`define CRL_KEY_MSB     2
`define CRL_KEY_UNLOCK  3'h3
`define CRL_KEY_LOCK    3'h6
`define CRL_CLR_BIT     0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CRL_RST_KEY     3'h0
`define CRL_RST_CFG_A   8'h80
`define CRL_RST_WORD    8'h00

`endif

// ---- crl_pkg.sv ----
// Types shared by the control register bank.
// Assumes crl_regs.svh sits in the include path.
`default_nettype none

package crl_pkg;
  // Lock state, one-hot
  typedef enum logic [1:0] {
    CRL_OPEN = 2'h1,  // Writes take effect
    CRL_SHUT = 2'h2   // Only key field writable
  } crl_lock_e;

  typedef logic [3:0] crl_addr_t;  // Register offset
  typedef logic [7:0] crl_byte_t;  // Register data
endpackage : crl_pkg

`default_nettype wire

// ---- crl_bank.sv ----
// Control register bank with write-protection key and lock state.
// Assumes a configuration-port front end on core_clk presents single
// byte-wide register reads and writes, one transaction per strobe.
`timescale 1ns/1ps
`default_nettype none
`include "crl_regs.svh"

// Functional notes
// - Key is three bits at offset 3h
// - Key 011b unlocks all registers
// - Key 110b locks; only key writable
// - Other key codes keep lock state
// - Key resets zero, bits 7-3 read zero
// - Offset 4h resets to 80h
// - Honour read-zero, clear-on-one, gated access
module crl_bank #(
  parameter crl_pkg::crl_byte_t WORD8_RST  = `CRL_RST_WORD,
  parameter crl_pkg::crl_byte_t WORD9_RST  = `CRL_RST_WORD,
  parameter crl_pkg::crl_byte_t WORD10_RST = `CRL_RST_WORD
) (
  input  wire logic               core_clk,
  input  wire logic               sys_rst,
  input  wire logic               wr_en,
  input  wire crl_pkg::crl_addr_t wr_addr,
  input  wire crl_pkg::crl_byte_t wr_data,
  input  wire logic               rd_en,
  input  wire crl_pkg::crl_addr_t rd_addr,
  output logic                    rd_valid,
  output crl_pkg::crl_byte_t      rd_data,
  output logic                    regs_locked,
  output logic [6:0]              drive_config_a,
  output logic                    clear_fault_pulse,
  output crl_pkg::crl_byte_t      control_word_eight,
  output crl_pkg::crl_byte_t      control_word_nine,
  output crl_pkg::crl_byte_t      control_word_ten
);
  import crl_pkg::*;

  // --------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------
  localparam crl_byte_t CFG_A_RST = `CRL_RST_CFG_A;  // Offset 4h reset byte

  crl_lock_e  lock_q;      // Current lock state
  logic [2:0] key_q;       // Last key code written
  logic [6:0] cfg_a_q;     // Offset 4h bits 7-1
  logic       clr_q;       // Clear-fault pulse
  crl_byte_t  word8_q;     // Offset ah
  crl_byte_t  word9_q;     // Offset bh
  crl_byte_t  word10_q;    // Offset ch
  crl_byte_t  rd_data_q;   // Read answer
  logic       rd_valid_q;  // Read answer valid

  // --------------------------------------------------------------------
  // Write decode
  // --------------------------------------------------------------------
  logic key_wr;    // Key write, always allowed
  logic open_wr;   // Write while unlocked
  logic key_rd;    // Read of key offset, for checks

  assign key_wr  = wr_en && (wr_addr == `CRL_OFF_KEY);
  assign open_wr = wr_en && (lock_q == CRL_OPEN);
  assign key_rd  = rd_en && (rd_addr == `CRL_OFF_KEY);

  // Lock state follows only the two valid codes
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lock_q <= CRL_OPEN;
    end else if (key_wr) begin
      case (wr_data[`CRL_KEY_MSB:0])
        `CRL_KEY_UNLOCK: lock_q <= CRL_OPEN;
        `CRL_KEY_LOCK:   lock_q <= CRL_SHUT;
        default:         lock_q <= lock_q;
      endcase
    end
  end

  // Key field, one whole write at a time
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      key_q <= `CRL_RST_KEY;
    end else if (key_wr) begin
      key_q <= wr_data[`CRL_KEY_MSB:0];
    end
  end

  // Offset 4h: plain bits plus self-clearing clear-fault bit
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_a_q <= CFG_A_RST[7:1];
      clr_q   <= 1'b0;
    end else begin
      clr_q <= 1'b0;
      if (open_wr && (wr_addr == `CRL_OFF_CFG_A)) begin
        cfg_a_q <= wr_data[7:1];
        clr_q   <= wr_data[`CRL_CLR_BIT];
      end
    end
  end

  // Plain control words, ignored while locked
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      word8_q  <= WORD8_RST;
      word9_q  <= WORD9_RST;
      word10_q <= WORD10_RST;
    end else if (open_wr) begin
      case (wr_addr)
        `CRL_OFF_WORD8:  word8_q  <= wr_data;
        `CRL_OFF_WORD9:  word9_q  <= wr_data;
        `CRL_OFF_WORD10: word10_q <= wr_data;
        default:         word8_q  <= word8_q;  // Unlisted: no effect
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Read path, one cycle latency
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data_q  <= 8'h00;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= rd_en;
      if (rd_en) begin
        case (rd_addr)
          `CRL_OFF_KEY:    rd_data_q <= {5'h00, key_q};
          `CRL_OFF_CFG_A:  rd_data_q <= {cfg_a_q, 1'b0};
          `CRL_OFF_WORD8:  rd_data_q <= word8_q;
          `CRL_OFF_WORD9:  rd_data_q <= word9_q;
          `CRL_OFF_WORD10: rd_data_q <= word10_q;
          default:         rd_data_q <= 8'h00;  // Unlisted reads zero
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign rd_valid           = rd_valid_q;
  assign rd_data            = rd_data_q;
  assign regs_locked        = (lock_q == CRL_SHUT);
  assign drive_config_a     = cfg_a_q;
  assign clear_fault_pulse  = clr_q;
  assign control_word_eight = word8_q;
  assign control_word_nine  = word9_q;
  assign control_word_ten   = word10_q;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // Lock code shuts the bank and freezes the offset ah word
  AST_LOCK_CODE: assert property (
    key_wr && wr_data[2:0] == 3'h6 |=> regs_locked ##1 $stable(word8_q)
  ) else $error("lock code did not lock");

  // Unlock code opens the bank
  AST_UNLOCK_CODE: assert property (
    key_wr && wr_data[2:0] == 3'h3 |=> !regs_locked
  ) else $error("unlock code did not unlock");

  // Any other code leaves the lock state alone
  AST_OTHER_CODE: assert property (
    key_wr && wr_data[2:0] != 3'h3 && wr_data[2:0] != 3'h6
      |=> $stable(regs_locked)
  ) else $error("other key code changed lock state");

  // Offset 4h frozen while locked
  AST_LOCKED_DROP: assert property (
    regs_locked && wr_en && wr_addr == 4'h4 |=> $stable(drive_config_a)
  ) else $error("write landed while locked");

  // Plain words frozen while locked
  AST_WORDS_LOCKED: assert property (
    regs_locked && wr_en && wr_addr != 4'h3
      |=> $stable(word8_q) && $stable(word9_q) && $stable(word10_q)
  ) else $error("control word changed while locked");

  // Key field keeps every code written
  AST_KEY_STORE: assert property (
    key_wr |=> key_q == $past(wr_data[2:0])
  ) else $error("key field not stored");

  // Key offset reads back the stored code
  AST_KEY_READ: assert property (
    $past(key_rd) |-> rd_data[2:0] == $past(key_q)
  ) else $error("key read back wrong");

  // Reserved key bits always read zero
  AST_KEY_UPPER: assert property (
    $past(key_rd) |-> rd_valid && rd_data[7:3] == 5'h00
  ) else $error("key upper bits not zero");

  // Writing one to the clear bit raises the pulse
  AST_CLR_PULSE: assert property (
    open_wr && wr_addr == 4'h4 && wr_data[0] |=> clear_fault_pulse
  ) else $error("clear-fault pulse wrong");

  // Pulse only ever follows such a write, so it lasts one cycle per write
  AST_CLR_CAUSE: assert property (
    clear_fault_pulse |-> $past(open_wr && wr_addr == 4'h4 && wr_data[0])
  ) else $error("clear-fault pulse without write");

  // Unlocked write to 4h lands in the plain bits
  AST_CFG_TAKE: assert property (
    open_wr && wr_addr == 4'h4 |=> drive_config_a == $past(wr_data[7:1])
  ) else $error("offset 4h write lost");

  // Clear bit always reads zero
  AST_RD_ZERO_BIT: assert property (
    $past(rd_en && rd_addr == 4'h4) |-> rd_valid && !rd_data[0]
  ) else $error("clear-fault bit read nonzero");

  // Read answer follows each strobe by one cycle
  AST_RD_VALID: assert property (
    rd_valid == $past(rd_en)
  ) else $error("read answer strobe wrong");

endmodule : crl_bank

`default_nettype wire

// ---- crl_host.sv ----
// Host model that drives the bank's byte-wide register port.
// Assumes core_clk comes from the bench; requests start at falling edges.
`timescale 1ns/1ps
`default_nettype none
module crl_host (
  input  wire logic               core_clk,
  output logic                    wr_en,
  output crl_pkg::crl_addr_t      wr_addr,
  output crl_pkg::crl_byte_t      wr_data,
  output logic                    rd_en,
  output crl_pkg::crl_addr_t      rd_addr,
  input  wire logic               rd_valid,
  input  wire crl_pkg::crl_byte_t rd_data
);
  import crl_pkg::*;
  // Idle port at time zero
  initial begin
    {wr_en, rd_en, wr_addr, rd_addr, wr_data} = '0;
  end
  // One write, to any offset given; lines inverted when released
  task automatic wr(input crl_addr_t a, input crl_byte_t d);
    @(negedge core_clk);
    {wr_en, wr_addr, wr_data} = {1'b1, a, d};
    @(negedge core_clk);
    {wr_en, wr_addr, wr_data} = {1'b0, ~a, ~d};
  endtask : wr
  // One read; answer taken in the cycle after the strobe
  task automatic rd(input crl_addr_t a, output crl_byte_t d, output logic v);
    @(negedge core_clk);
    {rd_en, rd_addr} = {1'b1, a};
    @(negedge core_clk);
    {rd_en, rd_addr, d, v} = {1'b0, ~a, rd_data, rd_valid};
  endtask : rd
endmodule : crl_host
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the control register bank.
// Assumes crl_host drives the register port at falling edges.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import crl_pkg::*;
  logic       core_clk = 1'b0;  // 200 MHz clock
  logic       sys_rst  = 1'b1;  // Async reset
  logic       wr_en, rd_en, rd_valid, regs_locked, clear_fault_pulse;
  crl_addr_t  wr_addr, rd_addr;  // Port offsets
  crl_byte_t  wr_data, rd_data, d;
  crl_byte_t  control_word_eight, control_word_nine, control_word_ten;
  logic [6:0] drive_config_a;    // Offset 4h bits 7-1
  logic       v;                 // Read answer valid
  int         mismatches = 0, samples_checked = 0, cycles = 0;
  always #2.5 core_clk = ~core_clk;
  crl_bank uut (.core_clk, .sys_rst, .wr_en, .wr_addr, .wr_data, .rd_en,
    .rd_addr, .rd_valid, .rd_data, .regs_locked, .drive_config_a,
    .clear_fault_pulse, .control_word_eight, .control_word_nine,
    .control_word_ten);
  crl_host host (.core_clk, .wr_en, .wr_addr, .wr_data, .rd_en, .rd_addr,
    .rd_valid, .rd_data);
  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // Read one offset and compare
  task automatic rchk(input crl_addr_t a, input crl_byte_t e);
    host.rd(a, d, v);
    chk({7'h0, v}, 8'h01);
    chk(d, e);
  endtask : rchk
  // Values straight after reset
  task automatic t_reset;
    chk({7'h0, regs_locked}, 8'h00);
    chk({1'b0, drive_config_a}, 8'h40);
    rchk(4'h3, 8'h00);
    rchk(4'h4, 8'h80);
    rchk(4'ha, 8'h00);
    rchk(4'hc, 8'h00);
    rchk(4'h8, 8'h00);
  endtask : t_reset
  // Every key code, reserved bits set; ends locked
  task automatic t_keys;
    logic lk;
    lk = 1'b0;
    for (int k = 0; k < 8; k++) begin
      host.wr(4'h3, 8'hf8 | 8'(k));
      lk = (k == 6) ? 1'b1 : (k == 3) ? 1'b0 : lk;
      chk({7'h0, regs_locked}, {7'h0, lk});
      rchk(4'h3, 8'(k));
    end
  endtask : t_keys
  // Locked bank drops writes but takes the key
  task automatic t_lock;
    host.wr(4'h4, 8'h3e);
    host.wr(4'ha, 8'h5a);
    chk({1'b0, drive_config_a}, 8'h40);
    chk(control_word_eight, 8'h00);
    host.wr(4'h4, 8'h01);
    chk({7'h0, clear_fault_pulse}, 8'h00);
    host.wr(4'h3, 8'h03);
    chk({7'h0, regs_locked}, 8'h00);
  endtask : t_lock
  // Clear bit pulses once and reads zero; words take data
  task automatic t_open;
    host.wr(4'h4, 8'h3f);
    chk({7'h0, clear_fault_pulse}, 8'h01);
    chk({1'b0, drive_config_a}, 8'h1f);
    @(negedge core_clk);
    chk({7'h0, clear_fault_pulse}, 8'h00);
    rchk(4'h4, 8'h3e);
    host.wr(4'ha, 8'h11);
    host.wr(4'hb, 8'h22);
    host.wr(4'hc, 8'h33);
    chk(control_word_eight, 8'h11);
    chk(control_word_nine, 8'h22);
    chk(control_word_ten, 8'h33);
    rchk(4'hb, 8'h22);
  endtask : t_open
  // Verdict and end of run
  task automatic close_out;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out
  // Hang guard
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      mismatches++;
      close_out();
    end
  end
  // Main sequence
  initial begin
    repeat (6) @(negedge core_clk);
    sys_rst = 1'b0;
    t_reset();
    t_keys();
    t_lock();
    t_open();
    close_out();
  end
endmodule : testbench
`default_nettype wire
